// >>> src/dps_host.sv
// host sequencer driving one port's token-space pins of a dual-port memory
`timescale 1ns/1ps
`default_nettype none
module dps_host (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // user command port
  input  wire logic                       cmd_valid,
  input  wire logic [1:0]                 cmd_op,
  input  wire logic [dps_pkg::IDX_W-1:0]  cmd_index,
  output logic                            cmd_ready,
  output logic                            done,
  output logic                            granted,
  // port pins toward the memory
  output logic                            mem_select_n,
  output logic                            token_space_select_n,
  output logic                            output_enable_n,
  output logic                            read_write_n,
  output logic [dps_pkg::IDX_W-1:0]       token_index_lines,
  output logic [dps_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe_n,
  input  wire logic [dps_pkg::DATA_W-1:0] data_in,
  input  wire logic                       port_conflict_flag
);
  typedef struct packed {
    dps_pkg::dps_st_t           st;
    logic [7:0]                 cnt;
    logic [1:0]                 op;
    logic [dps_pkg::IDX_W-1:0]  idx;
    logic                       wbit;
    logic                       last_rd;
    logic [7:0]                 polls;
    logic                       ready;
    logic                       done;
    logic                       granted;
    logic                       sem_n;
    logic                       oe_n;
    logic                       rw_n;
    logic [dps_pkg::DATA_W-1:0] dout;
    logic                       doe_n;
  } dps_host_t;

  localparam dps_host_t RESET_VAL = '{
    st: dps_pkg::DPS_IDLE, cnt: 8'h00, op: 2'h0, idx: 3'h0, wbit: 1'b1,
    last_rd: 1'b1, polls: 8'h00, ready: 1'b1, done: 1'b0, granted: 1'b0,
    sem_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, dout: 8'h00, doe_n: 1'b1};

  dps_host_t                  r_reg;
  dps_host_t                  r_next;
  logic [dps_pkg::DATA_W-1:0] din_s;
  logic                       flag_s;

  // data and conflict flag come from another device: two flops first
  dps_sync2 #(.W(dps_pkg::DATA_W + 1)) u_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in ({port_conflict_flag, data_in}),
    .sync_out ({flag_s, din_s})
  );

  // open a token write: select, index and data set up, write strobe still high
  function automatic dps_host_t start_write(input dps_host_t s);
    dps_host_t t;
    t       = s;
    t.st    = dps_pkg::DPS_WSET;
    t.sem_n = 1'b0;
    t.oe_n  = 1'b1;
    t.rw_n  = 1'b1;
    t.doe_n = 1'b0;
    t.dout  = {{(dps_pkg::DATA_W-1){1'b0}}, s.wbit}; // only bit zero matters
    t.cnt   = dps_pkg::SET_CYC - 8'h01;
    return t;
  endfunction : start_write

  // open a token read: both enables fall together so the value is captured
  function automatic dps_host_t start_read(input dps_host_t s);
    dps_host_t t;
    t       = s;
    t.st    = dps_pkg::DPS_RACC;
    t.sem_n = 1'b0;
    t.oe_n  = 1'b0;
    t.cnt   = dps_pkg::RD_CYC - 8'h01;
    return t;
  endfunction : start_read

  // sequencer
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (r_reg.cnt != 8'h00) begin
      r_next.cnt = r_reg.cnt - 8'h01;
    end
    case (r_reg.st)
      dps_pkg::DPS_IDLE: begin
        if (cmd_valid) begin
          r_next.ready = 1'b0;
          r_next.op    = cmd_op;
          r_next.polls = 8'h00;
          r_next.idx   = (cmd_op == dps_pkg::DPS_OP_INIT) ? 3'h0 : cmd_index;
          r_next.wbit  = (cmd_op != dps_pkg::DPS_OP_ACQUIRE);
          r_next       = start_write(r_next);
        end
      end
      dps_pkg::DPS_WSET: begin
        // strobe only once the flag reads high; a low flag blocks the write
        // one master decides the flag for the whole word; this host only obeys it
        if (r_reg.cnt == 8'h00 && flag_s) begin
          r_next.st   = dps_pkg::DPS_WPUL;
          r_next.rw_n = 1'b0;
          r_next.cnt  = dps_pkg::WP_CYC - 8'h01;
        end
      end
      dps_pkg::DPS_WPUL: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.st   = dps_pkg::DPS_WHLD;
          r_next.rw_n = 1'b1;
          r_next.cnt  = dps_pkg::HOLD_CYC - 8'h01;
        end
      end
      dps_pkg::DPS_WHLD: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.st    = dps_pkg::DPS_WGAP;
          r_next.sem_n = 1'b1;
          r_next.doe_n = 1'b1;
          r_next.cnt   = dps_pkg::GAP_CYC - 8'h01;
        end
      end
      dps_pkg::DPS_WGAP: begin
        if (r_reg.cnt == 8'h00) begin
          if (r_reg.op == dps_pkg::DPS_OP_ACQUIRE && !r_reg.wbit) begin
            r_next = start_read(r_next);
          end else if (r_reg.op == dps_pkg::DPS_OP_INIT && r_reg.idx != dps_pkg::LAST_IDX) begin
            r_next.idx = r_reg.idx + 3'h1;
            r_next     = start_write(r_next);
          end else begin
            r_next.st      = dps_pkg::DPS_IDLE;
            r_next.ready   = 1'b1;
            r_next.done    = 1'b1;
            r_next.granted = 1'b0;
          end
        end
      end
      dps_pkg::DPS_RACC: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.last_rd = din_s[0]; // every bit carries the flag
          r_next.st      = dps_pkg::DPS_RGAP;
          r_next.sem_n   = 1'b1;
          r_next.oe_n    = 1'b1;
          r_next.cnt     = dps_pkg::GAP_CYC - 8'h01;
        end
      end
      dps_pkg::DPS_RGAP: begin
        if (r_reg.cnt == 8'h00) begin
          if (!r_reg.last_rd) begin
            r_next.st      = dps_pkg::DPS_IDLE;
            r_next.ready   = 1'b1;
            r_next.done    = 1'b1;
            r_next.granted = 1'b1;
          end else if (r_reg.polls != dps_pkg::POLL_LIMIT) begin
            r_next.polls = r_reg.polls + 8'h01;
            r_next       = start_read(r_next);
          end else begin
            // withdraw so a stale request cannot hang the other side
            r_next.wbit = 1'b1;
            r_next      = start_write(r_next);
          end
        end
      end
      default: begin
        r_next = RESET_VAL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg <= RESET_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  // memory array is never used by this host, so its select stays high
  always_ff @(posedge clock) begin
    mem_select_n <= 1'b1;
  end

  assign cmd_ready            = r_reg.ready;
  assign done                 = r_reg.done;
  assign granted              = r_reg.granted;
  assign token_space_select_n = r_reg.sem_n;
  assign output_enable_n      = r_reg.oe_n;
  assign read_write_n         = r_reg.rw_n;
  assign token_index_lines    = r_reg.idx;
  assign data_out             = r_reg.dout;
  assign data_oe_n            = r_reg.doe_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  write_after_flag_a: assert property (
    $fell(read_write_n) |-> $past(flag_s) && !token_space_select_n && !data_oe_n)
    else $error("write strobe began before conflict flag was high");

  write_width_a: assert property (
    $fell(read_write_n) |-> (!read_write_n && !token_space_select_n) [*7] ##1 read_write_n)
    else $error("write pulse width or select hold wrong");

  request_value_a: assert property (
    !read_write_n |-> data_out[0] == r_reg.wbit
      && (r_reg.op != dps_pkg::DPS_OP_RELEASE || data_out[0]))
    else $error("token write carries wrong value");

  read_gap_a: assert property (
    $fell(output_enable_n) |-> $past(token_space_select_n) && !token_space_select_n)
    else $error("read started without select deasserted before");

  readback_grant_a: assert property (
    done && granted |-> !r_reg.last_rd && r_reg.op == dps_pkg::DPS_OP_ACQUIRE)
    else $error("grant reported without a zero read back");

  withdraw_fail_a: assert property (
    done && !granted && r_reg.op == dps_pkg::DPS_OP_ACQUIRE |-> r_reg.wbit
      && r_reg.polls == dps_pkg::POLL_LIMIT)
    else $error("failed request ended without polling and withdrawal");

  cov_grant_c: cover property (done && granted);
  cov_fail_c: cover property (done && !granted && r_reg.op == dps_pkg::DPS_OP_ACQUIRE);
  cov_init_c: cover property (done && r_reg.op == dps_pkg::DPS_OP_INIT);
endmodule : dps_host
`default_nettype wire

// >>> src/dps_pkg_sync.sv
// constants of the token-space host and its two-stage pin synchroniser
`timescale 1ns/1ps
`default_nettype none
package dps_pkg;
  // pin clock (MHz) and timing of one token-space cycle (times in ns)
  localparam int CLK_MHZ  = 250;
  localparam int SETUP_NS = 10;  // select and index stable before write pulse
  localparam int WRITE_NS = 28;  // write pulse width
  localparam int HOLD_NS  = 8;   // data held after write pulse
  localparam int GAP_NS   = 12;  // select inactive between accesses
  localparam int READ_NS  = 32;  // select and output enable to data valid
  localparam int SYNC_CYC = 2;   // input synchroniser latency

  // least time to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam logic [7:0] SET_CYC  = 8'(ns_to_cyc(SETUP_NS));
  localparam logic [7:0] WP_CYC   = 8'(ns_to_cyc(WRITE_NS));
  localparam logic [7:0] HOLD_CYC = 8'(ns_to_cyc(HOLD_NS));
  localparam logic [7:0] GAP_CYC  = 8'(ns_to_cyc(GAP_NS));
  localparam logic [7:0] RD_CYC   = 8'(ns_to_cyc(READ_NS) + SYNC_CYC);

  // polls after a failed request before the request is withdrawn
  localparam logic [7:0] POLL_LIMIT = 8'h04;
  localparam int         DATA_W     = 8;
  localparam int         IDX_W      = 3;
  localparam logic [2:0] LAST_IDX   = 3'h7;

  // user commands
  typedef enum logic [1:0] {
    DPS_OP_ACQUIRE = 2'h0,
    DPS_OP_RELEASE = 2'h1,
    DPS_OP_INIT    = 2'h2
  } dps_op_t;

  // one-hot sequencer states
  typedef enum logic [6:0] {
    DPS_IDLE = 7'h01,
    DPS_WSET = 7'h02,
    DPS_WPUL = 7'h04,
    DPS_WHLD = 7'h08,
    DPS_WGAP = 7'h10,
    DPS_RACC = 7'h20,
    DPS_RGAP = 7'h40
  } dps_st_t;
endpackage : dps_pkg

// two flip-flops per bit; only the second stage is visible outside
module dps_sync2 #(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dps_sync_t;

  dps_sync_t r_reg;
  dps_sync_t r_next;

  // shift chain; pins idle high so reset to ones
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = async_in;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.s2;
endmodule : dps_sync2
`default_nettype wire

// >>> verif/dps_sem_model.sv
// behavioural token space of the dual-port memory: left port pins, right port by task
`timescale 1ns/1ps
`default_nettype none
module dps_sem_model (
  // left port pins from the host
  input  wire logic       token_space_select_n,
  input  wire logic       output_enable_n,
  input  wire logic       read_write_n,
  input  wire logic [2:0] token_index_lines,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output wire logic [7:0] data_in,
  // write inhibit, seen as a slave input
  input  wire logic       conflict_flag
);
  // request latches (0 = request); owner 0 none, 1 left, 2 right; not cleared at power-up
  logic [7:0] req_l = 8'h00;
  logic [7:0] req_r = 8'h00;
  logic [1:0] own [8] = '{default: 2'h1};
  logic [7:0] lat = 8'h00;
  logic [7:0] last_d = 8'h00;
  int polls = 0;
  int writes = 0;
  wire rd_l = !token_space_select_n && !output_enable_n && read_write_n;

  // events are serialised, so the earlier request always wins; nothing else is gated
  task automatic wr(input bit right, input int i, input logic v);
    if (right) begin
      req_r[i] = v;
    end else begin
      req_l[i] = v;
    end
    if (own[i] == 2'h1 && req_l[i]) begin
      own[i] = req_r[i] ? 2'h0 : 2'h2;
    end else if (own[i] == 2'h2 && req_r[i]) begin
      own[i] = req_l[i] ? 2'h0 : 2'h1;
    end
    if (own[i] == 2'h0) begin
      own[i] = !req_l[i] ? 2'h1 : (!req_r[i] ? 2'h2 : 2'h0);
    end
  endtask : wr

  // value frozen at the start of a read; a poll needs a fresh select to see news
  always @(posedge rd_l) begin
    lat <= {8{own[token_index_lines] != 2'h1}};
    polls <= polls + 1;
  end
  // released bus shows the inverse so a stale value never looks valid
  assign data_in = rd_l ? lat : ~lat;

  // write commits at the end of the strobe; only bit zero matters, low flag blocks it
  always @(posedge read_write_n) begin
    if (!token_space_select_n && !data_oe_n && conflict_flag) begin
      last_d <= data_out;
      wr(1'b0, int'(token_index_lines), data_out[0]);
    end
  end
  // count write strobes started in token space
  always @(negedge read_write_n) begin
    if (!token_space_select_n) begin
      writes <= writes + 1;
    end
  end
endmodule : dps_sem_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench: host on the left port, right processor played by model tasks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [2:0] cmd_index = 3'h0;
  logic       conflict_flag = 1'b1;
  logic       cmd_ready, done, granted, mem_select_n, sem_n, oe_n, rw_n, doe_n;
  logic [2:0] idx;
  logic [7:0] dout, din;
  logic       got_g;
  int         fails = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         base;

  always #2 clock = ~clock;

  dps_host u_dut (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_ready(cmd_ready), .done(done), .granted(granted),
    .mem_select_n(mem_select_n), .token_space_select_n(sem_n), .output_enable_n(oe_n),
    .read_write_n(rw_n), .token_index_lines(idx), .data_out(dout), .data_oe_n(doe_n),
    .data_in(din), .port_conflict_flag(conflict_flag));
  dps_sem_model u_model (.token_space_select_n(sem_n), .output_enable_n(oe_n),
    .read_write_n(rw_n), .token_index_lines(idx), .data_out(dout), .data_oe_n(doe_n),
    .data_in(din), .conflict_flag(conflict_flag));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // the whole run needs under 500 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // command held one cycle; the host is idle so it is taken at the next rising edge
  task automatic issue(input logic [1:0] op, input logic [2:0] i);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = i;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clock);
      n = n + 1;
    end
    got_g = granted;
    check("done", 8'h01, {7'h0, done});
  endtask : wait_done

  task automatic run(input logic [1:0] op, input logic [2:0] i, input logic exp_g);
    issue(op, i);
    wait_done();
    check("granted", {7'h0, exp_g}, {7'h0, got_g});
  endtask : run

  task automatic t_init();
    run(2'h2, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      u_model.wr(1'b1, i, 1'b1);
      check("token free", 8'h00, {6'h0, u_model.own[i]});
    end
    check("left requests", 8'hff, u_model.req_l);
    check("write data", 8'h01, u_model.last_d);
    $display("end of init test");
  endtask : t_init

  task automatic t_acquire();
    run(2'h0, 3'h5, 1'b1);
    check("owner", 8'h01, {6'h0, u_model.own[5]});
    check("read value", 8'h00, u_model.lat);
    run(2'h1, 3'h5, 1'b0);
    check("owner", 8'h00, {6'h0, u_model.own[5]});
    check("write data", 8'h01, u_model.last_d);
    // the spare opcode must act as a plain release
    run(2'h0, 3'h4, 1'b1);
    run(2'h3, 3'h4, 1'b0);
    check("owner", 8'h00, {6'h0, u_model.own[4]});
    $display("end of acquire test");
  endtask : t_acquire

  task automatic t_contend();
    u_model.wr(1'b1, 2, 1'b0);
    base = u_model.polls;
    run(2'h0, 3'h2, 1'b0);
    check("polls", 8'h05, 8'(u_model.polls - base));
    check("read value", 8'hff, u_model.lat);
    check("withdrawn", 8'h01, {7'h0, u_model.req_l[2]});
    check("owner", 8'h02, {6'h0, u_model.own[2]});
    u_model.wr(1'b1, 2, 1'b1);
    $display("end of contention test");
  endtask : t_contend

  task automatic t_handover();
    run(2'h0, 3'h3, 1'b1);
    u_model.wr(1'b1, 3, 1'b0);
    check("owner", 8'h01, {6'h0, u_model.own[3]});
    run(2'h1, 3'h3, 1'b0);
    check("owner", 8'h02, {6'h0, u_model.own[3]});
    u_model.wr(1'b1, 3, 1'b1);
    $display("end of handover test");
  endtask : t_handover

  task automatic t_inhibit();
    run(2'h0, 3'h6, 1'b1);
    // the far port holds no request on this token; the bench drives the flag low by hand for this release
    conflict_flag = 1'b0;
    base = u_model.writes;
    issue(2'h1, 3'h6);
    repeat (40) @(negedge clock);
    check("strobes", 8'h00, 8'(u_model.writes - base));
    check("ready", 8'h00, {7'h0, cmd_ready});
    conflict_flag = 1'b1;
    wait_done();
    check("strobes", 8'h01, 8'(u_model.writes - base));
    check("owner", 8'h00, {6'h0, u_model.own[6]});
    $display("end of inhibit test");
  endtask : t_inhibit

  initial begin
    repeat (16) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    check("idle pins", 8'h3f, {2'h0, cmd_ready, sem_n, oe_n, rw_n, doe_n, mem_select_n});
    t_init();
    t_acquire();
    t_contend();
    t_handover();
    t_inhibit();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
